/* File: logic/coa_pkg.sv */
/*
 * Constants and carrier types for the charger option and alert registers.
 * Assumes a 125 MHz system clock; times are given in ns and turned into
 * clock-cycle counts here.
 */
package coa_pkg;

	// register offsets on the documented register port
	localparam logic [7:0] COA_OFS_MODE_CTRL  = 8'h35;
	localparam logic [7:0] COA_OFS_ALERT_THR  = 8'h36;
	localparam logic [7:0] COA_OFS_ILIM_ALERT = 8'h37;
	localparam logic [7:0] COA_OFS_SRC_EN     = 8'h38;

	// values after reset; all but the floor value are also loaded by a register restore
	localparam logic [7:0]  COA_RST_MODE_CTRL  = 8'h00;
	localparam logic [7:0]  COA_RST_ALERT_THR  = 8'h65;
	localparam logic [7:0]  COA_RST_ILIM_ALERT = 8'h4A;
	localparam logic [7:0]  COA_RST_SRC_EN     = 8'hA0;
	localparam logic [15:0] COA_RST_FLOOR_MV   = 16'h0DAC;

	// field positions in charger_mode_control
	localparam int COA_BIT_HIZ      = 7;
	localparam int COA_BIT_RESTORE  = 6;
	localparam int COA_BIT_REMEAS   = 5;
	localparam logic [7:0] COA_MODE_RESERVED_MASK = 8'h07;

	// field positions in alert_threshold_config
	localparam int COA_ASSIST_LSB   = 4;
	localparam int COA_ALERT_LSB    = 2;
	localparam int COA_BIT_NOM_FILT = 1;
	localparam int COA_BIT_REDUCED  = 0;

	// field positions in current_limit_alert_config
	localparam int COA_ILIM2_LSB    = 3;
	localparam int COA_CRIT_LSB     = 1;
	localparam int COA_BIT_RATIO90  = 0;

	// second limit code ranges
	localparam logic [4:0] COA_ILIM2_FINE_MAX = 5'h19;
	localparam logic [4:0] COA_ILIM2_OFF      = 5'h1F;

	// clock period and deglitch times
	localparam int COA_CLK_PERIOD_NS = 8;
	localparam int COA_NOM_SHORT_NS  = 1_000_000;
	localparam int COA_NOM_LONG_NS   = 50_000_000;
	localparam int COA_CRIT_0_NS     = 15_000;
	localparam int COA_CRIT_1_NS     = 100_000;
	localparam int COA_CRIT_2_NS     = 400_000;
	localparam int COA_CRIT_3_NS     = 800_000;

	// least times round up to whole cycles
	localparam int COA_NOM_SHORT_CYC =
		(COA_NOM_SHORT_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_NOM_LONG_CYC  =
		(COA_NOM_LONG_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_CRIT_0_CYC    =
		(COA_CRIT_0_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_CRIT_1_CYC    =
		(COA_CRIT_1_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_CRIT_2_CYC    =
		(COA_CRIT_2_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_CRIT_3_CYC    =
		(COA_CRIT_3_NS + COA_CLK_PERIOD_NS - 1) / COA_CLK_PERIOD_NS;
	localparam int COA_DEG_W         = 23;

	// register port request
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} coa_reg_req_s;

	// input-floor re-measure sequencer
	typedef enum logic [1:0] {
		COA_ST_IDLE    = 2'b00,
		COA_ST_STOP    = 2'b01,
		COA_ST_MEASURE = 2'b10,
		COA_ST_STORE   = 2'b11
	} coa_state_e;

endpackage : coa_pkg

/* File: logic/coa_charger_option_alert_regs.sv */
/*
 * Option and processor-hot alert registers of a buck-boost charger:
 * high-impedance control, register restore, input-floor re-measure,
 * assist/alert thresholds, second current limit and alert deglitch.
 * Assumes a simple synchronous register port from the serial bus
 * engine and analog measurements already digitised in mV / mA.
 */
// How it works
// RQ1 - bit 7 enables high-impedance mode, reset off
// RQ2 - restore reloads defaults, floor value kept
// RQ3 - restore: single-cell system minimum, strap-chosen charge voltage
// RQ4 - restore bit clears itself when done
// RQ5 - re-measure stops converter, measures, stores floor
// RQ6 - after store, bit clears and converter resumes
// RQ7 - host writes zero to reserved bits 2-0
// RQ8 - multi-cell assist threshold 5.9-7.4 V, 0.1 V
// RQ9 - single-cell assist 3.1-3.8 V, top bit ignored
// RQ10 - alert threshold codes map 5.9/3.1 V upward
// RQ11 - nominal current deglitch 1 ms or 50 ms
// RQ12 - floor alert at 100 percent or reduced
// RQ13 - second limit codes 1-25: 110-230 percent
// RQ14 - codes 26-30: 250-450 percent, 31 disables
// RQ15 - second limit scales input current limit, default 150
// RQ16 - critical deglitch 15/100/400/800 us
// RQ17 - reduced floor alert 80 or 90 percent
// RQ18 - defaults on reset, deglitch restarts on drop
`timescale 1ns/1ps
module coa_charger_option_alert_regs
	import coa_pkg::*;
#(
	parameter logic [COA_DEG_W-1:0] NOM_SHORT_CYC = COA_DEG_W'(COA_NOM_SHORT_CYC),
	parameter logic [COA_DEG_W-1:0] NOM_LONG_CYC  = COA_DEG_W'(COA_NOM_LONG_CYC),
	parameter logic [COA_DEG_W-1:0] CRIT_1_CYC    = COA_DEG_W'(COA_CRIT_1_CYC),
	parameter logic [COA_DEG_W-1:0] CRIT_2_CYC    = COA_DEG_W'(COA_CRIT_2_CYC),
	parameter logic [COA_DEG_W-1:0] CRIT_3_CYC    = COA_DEG_W'(COA_CRIT_3_CYC)
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	// register port
	input  wire coa_reg_req_s  i_reg_req,
	output logic [7:0]         o_reg_rdata,
	// straps and measurements
	input  wire logic [1:0]    i_cell_count_strap,
	input  wire logic          i_measure_valid,
	input  wire logic [15:0]   i_measure_mv,
	input  wire logic [15:0]   i_input_rail_mv,
	input  wire logic [15:0]   i_sys_rail_mv,
	input  wire logic [15:0]   i_input_current_limit_ma,
	input  wire logic          i_nominal_current_event,
	input  wire logic          i_critical_current_event,
	// converter control
	output logic               o_high_impedance_enable,
	output logic               o_converter_stop,
	output logic               o_measure_req,
	output logic [15:0]        o_input_voltage_floor,
	output logic               o_sysmin_single_cell,
	output logic               o_charge_voltage_load,
	output logic [1:0]         o_charge_voltage_cells,
	// thresholds and alert
	output logic [15:0]        o_assist_threshold_mv,
	output logic [15:0]        o_alert_threshold_mv,
	output logic [15:0]        o_floor_alert_threshold_mv,
	output logic [8:0]         o_second_limit_pct,
	output logic               o_second_limit_enable,
	output logic [18:0]        o_second_limit_ma,
	output logic [7:0]         o_alert_source_enables,
	output logic               o_processor_hot_alert
);

	// refuse zero counts, which would hold the alert on with no event at all
	if (NOM_SHORT_CYC == 0 || NOM_LONG_CYC == 0 || CRIT_1_CYC == 0 ||
		CRIT_2_CYC == 0 || CRIT_3_CYC == 0) begin : g_bad_count
		$error("deglitch counts must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////
	// register storage and decode

	logic [7:0]  mode_reg;
	logic [7:0]  thr_reg;
	logic [7:0]  ilim_reg;
	logic [7:0]  src_reg;
	logic [15:0] floor_reg;
	coa_state_e  state_reg;
	coa_state_e  state_next;

	wire wr_mode = i_reg_req.wr && i_reg_req.addr == COA_OFS_MODE_CTRL;
	wire wr_thr  = i_reg_req.wr && i_reg_req.addr == COA_OFS_ALERT_THR;
	wire wr_ilim = i_reg_req.wr && i_reg_req.addr == COA_OFS_ILIM_ALERT;
	wire wr_src  = i_reg_req.wr && i_reg_req.addr == COA_OFS_SRC_EN;
	// a restore runs in the cycle after the bit was written
	wire restore = mode_reg[COA_BIT_RESTORE];
	wire meas_done = state_reg == COA_ST_MEASURE && i_measure_valid;
	// the hardware clear loses to a host write arriving the same cycle
	wire remeas_clear = state_reg == COA_ST_STORE && !wr_mode;
	wire single_cell = i_cell_count_strap == 2'b00;

	// reserved bits keep their stored value whatever the host writes
	wire [7:0] mode_wdata = (i_reg_req.data & ~COA_MODE_RESERVED_MASK) |
		(mode_reg & COA_MODE_RESERVED_MASK);

	// configuration registers; restore beats all but the floor value
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || restore) begin // RQ2 RQ18
			mode_reg <= COA_RST_MODE_CTRL; // RQ1 RQ4
			thr_reg  <= COA_RST_ALERT_THR;
			ilim_reg <= COA_RST_ILIM_ALERT; // RQ15
			src_reg  <= COA_RST_SRC_EN;
		end else begin
			if (wr_mode)
				mode_reg <= mode_wdata; // RQ1 RQ7
			else if (remeas_clear)
				mode_reg[COA_BIT_REMEAS] <= 1'b0; // RQ6
			if (wr_thr)
				thr_reg <= i_reg_req.data;
			if (wr_ilim)
				ilim_reg <= i_reg_req.data;
			if (wr_src)
				src_reg <= i_reg_req.data;
		end
	end

	// floor value: only power-on reset and a measurement touch it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			floor_reg <= COA_RST_FLOOR_MV;
		else if (meas_done)
			floor_reg <= i_measure_mv; // RQ5
	end

	// read mux; unmapped offsets read as zero
	wire [7:0] rd_mux =
		(i_reg_req.addr == COA_OFS_MODE_CTRL)  ? mode_reg :
		(i_reg_req.addr == COA_OFS_ALERT_THR)  ? thr_reg  :
		(i_reg_req.addr == COA_OFS_ILIM_ALERT) ? ilim_reg :
		(i_reg_req.addr == COA_OFS_SRC_EN)     ? src_reg  : 8'h00;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			o_reg_rdata <= 8'h00;
		else
			o_reg_rdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// input-floor re-measure sequencer

	// one stop cycle lets the converter settle before sampling
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			COA_ST_IDLE:
				if (mode_reg[COA_BIT_REMEAS])
					state_next = COA_ST_STOP; // RQ5
			COA_ST_STOP:
				state_next = COA_ST_MEASURE;
			COA_ST_MEASURE:
				if (i_measure_valid)
					state_next = COA_ST_STORE;
			COA_ST_STORE:
				state_next = COA_ST_IDLE; // RQ6
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || restore)
			state_reg <= COA_ST_IDLE;
		else
			state_reg <= state_next;
	end

	assign o_converter_stop = state_reg != COA_ST_IDLE; // RQ5
	assign o_measure_req    = state_reg == COA_ST_MEASURE;

	////////////////////////////////////////////////////////////////////////
	// threshold decode

	wire [3:0] assist_code = thr_reg[COA_ASSIST_LSB +: 4];
	wire [1:0] alert_code  = thr_reg[COA_ALERT_LSB +: 2];
	wire [4:0] ilim2_code  = ilim_reg[COA_ILIM2_LSB +: 5];
	wire [1:0] crit_code   = ilim_reg[COA_CRIT_LSB +: 2];

	// single-cell packs ignore the top code bit
	wire [15:0] assist_mv = single_cell ?
		16'(3100 + 100 * int'(assist_code[2:0])) : // RQ9
		16'(5900 + 100 * int'(assist_code)); // RQ8
	wire [15:0] alert_mv = single_cell ?
		16'(3100 + 200 * int'(alert_code)) :
		16'(5900 + 300 * int'(alert_code)); // RQ10
	wire [6:0] floor_pct = !thr_reg[COA_BIT_REDUCED] ? 7'd100 : // RQ12
		(ilim_reg[COA_BIT_RATIO90] ? 7'd90 : 7'd80); // RQ17
	wire [22:0] floor_prod = floor_reg * floor_pct;
	wire [15:0] floor_thr  = 16'(floor_prod / 23'd100);

	// coarse codes step by 50, code 0 is treated as off as well
	wire ilim2_on = ilim2_code != COA_ILIM2_OFF && ilim2_code != 5'h00; // RQ14
	wire [8:0] ilim2_pct = !ilim2_on ? 9'd0 :
		(ilim2_code <= COA_ILIM2_FINE_MAX) ?
		9'(105 + 5 * int'(ilim2_code)) : // RQ13
		9'(250 + 50 * (int'(ilim2_code) - 26)); // RQ14
	wire [24:0] ilim2_prod = i_input_current_limit_ma * ilim2_pct;

	// decoded values are registered so downstream sees clean levels
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_assist_threshold_mv      <= 16'h0000;
			o_alert_threshold_mv       <= 16'h0000;
			o_floor_alert_threshold_mv <= 16'h0000;
			o_second_limit_pct         <= 9'h000;
			o_second_limit_enable      <= 1'b0;
			o_second_limit_ma          <= 19'h00000;
		end else begin
			o_assist_threshold_mv      <= assist_mv;
			o_alert_threshold_mv       <= alert_mv;
			o_floor_alert_threshold_mv <= floor_thr;
			o_second_limit_pct         <= ilim2_pct;
			o_second_limit_enable      <= ilim2_on;
			o_second_limit_ma          <= 19'(ilim2_prod / 25'd100); // RQ15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// deglitch and alert

	logic [COA_DEG_W-1:0] nom_cnt_reg;
	logic [COA_DEG_W-1:0] crit_cnt_reg;

	wire [COA_DEG_W-1:0] nom_target = thr_reg[COA_BIT_NOM_FILT] ?
		NOM_LONG_CYC : NOM_SHORT_CYC; // RQ11
	wire [COA_DEG_W-1:0] crit_target =
		(crit_code == 2'b00) ? COA_DEG_W'(COA_CRIT_0_CYC) :
		(crit_code == 2'b01) ? CRIT_1_CYC :
		(crit_code == 2'b10) ? CRIT_2_CYC : CRIT_3_CYC; // RQ16
	wire nom_ok  = nom_cnt_reg >= nom_target;
	wire crit_ok = crit_cnt_reg >= crit_target;

	// a dropped condition restarts the count from zero
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_nominal_current_event)
			nom_cnt_reg <= '0; // RQ18
		else if (!nom_ok)
			nom_cnt_reg <= nom_cnt_reg + 1'b1;
		if (!i_rst_n || !i_critical_current_event)
			crit_cnt_reg <= '0; // RQ18
		else if (!crit_ok)
			crit_cnt_reg <= crit_cnt_reg + 1'b1;
	end

	wire sys_low   = i_sys_rail_mv < o_alert_threshold_mv; // RQ10
	wire floor_low = i_input_rail_mv < o_floor_alert_threshold_mv; // RQ12

	// restore pulses and registered alert
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_processor_hot_alert  <= 1'b0;
			o_sysmin_single_cell   <= 1'b0;
			o_charge_voltage_load  <= 1'b0;
			o_charge_voltage_cells <= 2'b00;
		end else begin
			o_processor_hot_alert  <= sys_low | floor_low | nom_ok | crit_ok;
			o_sysmin_single_cell   <= restore; // RQ3
			o_charge_voltage_load  <= restore;
			if (restore)
				o_charge_voltage_cells <= i_cell_count_strap; // RQ3
		end
	end

	assign o_high_impedance_enable = mode_reg[COA_BIT_HIZ]; // RQ1
	assign o_input_voltage_floor   = floor_reg;
	assign o_alert_source_enables  = src_reg;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_restore_req;
		wr_mode && i_reg_req.data[COA_BIT_RESTORE] ##1 !i_reg_req.wr;
	endsequence
	sequence s_meas_done;
		state_reg == COA_ST_MEASURE && i_measure_valid;
	endsequence

	property p_hiz_write;
		wr_mode && !i_reg_req.data[COA_BIT_RESTORE] && !restore |=>
			o_high_impedance_enable == $past(i_reg_req.data[7]);
	endproperty
	a_hiz_write: assert property (p_hiz_write) else $error("hiz bit lost"); // RQ1

	property p_restore_defaults;
		s_restore_req |=> thr_reg == 8'h65 && ilim_reg == 8'h4A &&
			src_reg == 8'hA0 && floor_reg == $past(floor_reg);
	endproperty
	a_restore_defaults: assert property (p_restore_defaults) // RQ2
		else $error("restore did not reload defaults");

	property p_restore_clears;
		s_restore_req |=> !mode_reg[COA_BIT_RESTORE] ##1
			!mode_reg[COA_BIT_RESTORE] || $past(i_reg_req.wr);
	endproperty
	a_restore_clears: assert property (p_restore_clears) // RQ4
		else $error("restore bit did not clear");

	property p_restore_pulse;
		restore |=> o_sysmin_single_cell && o_charge_voltage_load &&
			o_charge_voltage_cells == $past(i_cell_count_strap);
	endproperty
	a_restore_pulse: assert property (p_restore_pulse) // RQ3
		else $error("restore pulses wrong");

	property p_stop_measure;
		$rose(mode_reg[COA_BIT_REMEAS]) && state_reg == COA_ST_IDLE
			&& !restore |=> o_converter_stop ##1 o_measure_req;
	endproperty
	a_stop_measure: assert property (p_stop_measure) // RQ5
		else $error("converter not stopped for measure");

	property p_store_resume;
		s_meas_done ##1 !i_reg_req.wr && !restore |=>
			o_input_voltage_floor == $past(i_measure_mv, 2) &&
			!o_converter_stop && !mode_reg[COA_BIT_REMEAS];
	endproperty
	a_store_resume: assert property (p_store_resume) // RQ6
		else $error("floor not stored or converter not resumed");

	// decoded outputs still hold their reset zero one cycle after release
	property p_assist_map;
		$past(i_rst_n) && $stable(thr_reg) &&
			$stable(i_cell_count_strap) |->
			o_assist_threshold_mv == (single_cell ?
			16'(3100 + 100 * (thr_reg[6:4])) :
			16'(5900 + 100 * (thr_reg[7:4])));
	endproperty
	a_assist_map: assert property (p_assist_map) // RQ8 RQ9
		else $error("assist threshold wrong");

	property p_floor_ratio;
		$past(i_rst_n) && $stable(thr_reg) && $stable(ilim_reg) &&
			$stable(floor_reg) |->
			o_floor_alert_threshold_mv == 16'(floor_reg *
			(!thr_reg[0] ? 100 : ilim_reg[0] ? 90 : 80) / 100);
	endproperty
	a_floor_ratio: assert property (p_floor_ratio) // RQ12 RQ17
		else $error("floor alert threshold wrong");

	property p_ilim2_off;
		ilim_reg[7:3] == 5'h1F |=> !o_second_limit_enable;
	endproperty
	a_ilim2_off: assert property (p_ilim2_off) // RQ14
		else $error("second limit not disabled");

	property p_deglitch_restart;
		(!i_nominal_current_event |=> nom_cnt_reg == '0) and
			(!i_critical_current_event |=> crit_cnt_reg == '0);
	endproperty
	a_deglitch_restart: assert property (p_deglitch_restart) // RQ18
		else $error("deglitch count not restarted");

endmodule : coa_charger_option_alert_regs

/* File: tb/coa_host_model.sv */
/*
 * Host side of the register port: one write or one read at a time.
 * Assumes read data follows the address by one clock.
 */
`timescale 1ns/1ps
module coa_host_model
	import coa_pkg::*;
(
	// clock and read data
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_clk,
	// request to the block
	output coa_reg_req_s    o_req
);
	////////////////////////////////////////////////////////////////////
	// idle: strobe low, data flipped so stale data never looks fresh
	initial o_req = '{wr: 1'b0, addr: 8'h00, data: 8'hFF};

	// write taken at the second edge; reserved mode bits sent as zero
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] dm;
		dm = d;
		if (a == COA_OFS_MODE_CTRL)
			dm = d & ~COA_MODE_RESERVED_MASK;
		@(posedge i_clk);
		#1;
		o_req = '{wr: 1'b1, addr: a, data: dm};
		@(posedge i_clk);
		#1;
		o_req.wr = 1'b0;
		o_req.data = ~dm;
	endtask : wr_reg

	// read: address held one edge, data taken after the next
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_req.addr = a;
		@(posedge i_clk);
		#1;
		d = i_rdata;
	endtask : rd_reg
endmodule : coa_host_model

/* File: tb/charger_option_alert_regs_tb.sv */
/*
 * Self-checking bench for the option and alert registers.
 * Assumes short deglitch counts set through the parameters below.
 */
`timescale 1ns/1ps
module charger_option_alert_regs_tb
	import coa_pkg::*;
;
	// shortened deglitch counts
	localparam int NS = 20;
	localparam int NL = 50;
	localparam int C1 = 10;
	localparam int C2 = 30;
	localparam int C3 = 40;

	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	coa_reg_req_s req;
	logic [7:0]   rdata, rv, srcen;
	logic [1:0]   strap = 2'h3;
	logic [1:0]   cells;
	logic         mvalid = 1'b0;
	logic         nom = 1'b0;
	logic         crit = 1'b0;
	logic [15:0]  mmv = 16'h0000;
	logic [15:0]  vin = 16'h4E20;
	logic [15:0]  vsys = 16'h4E20;
	logic [15:0]  ilim = 16'h07D0;
	logic         hiz, stop, mreq, sys1, cvld, s2en, alert;
	logic [15:0]  floor, assist, athr, fthr;
	logic [8:0]   s2pct;
	logic [18:0]  s2ma;
	int           fails = 0;
	int           total_checks = 0;

	////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	always #4 clk = ~clk;

	coa_charger_option_alert_regs #(
		.NOM_SHORT_CYC(23'(NS)),
		.NOM_LONG_CYC (23'(NL)),
		.CRIT_1_CYC   (23'(C1)),
		.CRIT_2_CYC   (23'(C2)),
		.CRIT_3_CYC   (23'(C3))
	) u_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
		.i_cell_count_strap(strap), .i_measure_valid(mvalid),
		.i_measure_mv(mmv), .i_input_rail_mv(vin), .i_sys_rail_mv(vsys),
		.i_input_current_limit_ma(ilim), .i_nominal_current_event(nom),
		.i_critical_current_event(crit), .o_high_impedance_enable(hiz),
		.o_converter_stop(stop), .o_measure_req(mreq),
		.o_input_voltage_floor(floor), .o_sysmin_single_cell(sys1),
		.o_charge_voltage_load(cvld), .o_charge_voltage_cells(cells),
		.o_assist_threshold_mv(assist), .o_alert_threshold_mv(athr),
		.o_floor_alert_threshold_mv(fthr), .o_second_limit_pct(s2pct),
		.o_second_limit_enable(s2en), .o_second_limit_ma(s2ma),
		.o_alert_source_enables(srcen), .o_processor_hot_alert(alert)
	);

	coa_host_model u_host (.i_rdata(rdata), .i_clk(clk), .o_req(req));

	////////////////////////////////////////////////////////////////////
	// verdict and run end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// output value compare
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	// register readback compare
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		u_host.rd_reg(a, rv);
		total_checks++;
		if (rv !== e) begin
			fails++;
			$display("[FAIL] reg %0h expected %0h seen %0h", a, e, rv);
		end
	endtask : chk_reg

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// a wait that ran out ends the run
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			fails++;
			$display("[FAIL] wait expected done seen timeout");
			end_of_test();
		end
	endtask : tmo

	task automatic set_ev(input logic s, input logic v);
		if (s)
			crit = v;
		else
			nom = v;
	endtask : set_ev

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk_reg(COA_OFS_MODE_CTRL, 8'h00);
		chk_reg(COA_OFS_ALERT_THR, 8'h65);
		chk_reg(COA_OFS_ILIM_ALERT, 8'h4A);
		chk_reg(COA_OFS_SRC_EN, 8'hA0);
		u_host.wr_reg(8'h40, 8'h5A);
		chk_reg(8'h40, 8'h00);
		chk("hiz", 1'b0, hiz);
		chk("floor", COA_RST_FLOOR_MV, floor);
	endtask : t_reset

	// reserved bits go out as zero from the host model
	task automatic t_hiz();
		u_host.wr_reg(COA_OFS_MODE_CTRL, 8'h87);
		cyc(1);
		chk("hiz", 1'b1, hiz);
		chk_reg(COA_OFS_MODE_CTRL, 8'h80);
		u_host.wr_reg(COA_OFS_MODE_CTRL, 8'h00);
		cyc(1);
		chk("hiz", 1'b0, hiz);
	endtask : t_hiz

	// strap and code table, expectations from the step rules
	task automatic t_thr();
		logic [1:0] st [8] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
		logic [7:0] cf [8] = '{8'h01, 8'hF5, 8'h69, 8'h7D, 8'h81, 8'hF5,
			8'h79, 8'h0D};
		int ea, el;
		logic s1;
		for (int i = 0; i < 8; i++) begin
			strap = st[i];
			u_host.wr_reg(COA_OFS_ALERT_THR, cf[i]);
			cyc(2);
			s1 = (st[i] == 2'h0);
			ea = s1 ? 3100 + 100 * cf[i][6:4] : 5900 + 100 * cf[i][7:4];
			el = s1 ? 3100 + 200 * cf[i][3:2] : 5900 + 300 * cf[i][3:2];
			chk("assist", ea, assist);
			chk("alert_thr", el, athr);
		end
		strap = 2'h3;
		u_host.wr_reg(COA_OFS_ALERT_THR, 8'h65);
		vsys = 16'h17D4;
		cyc(3);
		chk("alert", 1'b1, alert);
		vsys = 16'h189C;
		cyc(3);
		chk("alert", 1'b0, alert);
		vsys = 16'h4E20;
	endtask : t_thr

	// every second-limit code
	task automatic t_ilim();
		int p;
		for (int c = 0; c < 32; c++) begin
			u_host.wr_reg(COA_OFS_ILIM_ALERT, {c[4:0], 3'h2});
			cyc(2);
			p = (c == 0 || c == 31) ? 0 :
				(c <= 25) ? 105 + 5 * c : 250 + 50 * (c - 26);
			chk("pct", p, s2pct);
			chk("enable", p != 0, s2en);
			if (p != 0)
				chk("limit_ma", 2000 * p / 100, s2ma);
		end
		u_host.wr_reg(COA_OFS_ILIM_ALERT, 8'h4A);
	endtask : t_ilim

	task automatic t_remeas();
		int n;
		u_host.wr_reg(COA_OFS_MODE_CTRL, 8'h20);
		for (n = 0; n < 10 && mreq !== 1'b1; n++)
			cyc(1);
		tmo(n, 10);
		chk("stop", 1'b1, stop);
		chk_reg(COA_OFS_MODE_CTRL, 8'h20);
		mmv = 16'h1068;
		mvalid = 1'b1;
		cyc(1);
		mvalid = 1'b0;
		mmv = ~mmv;
		for (n = 0; n < 10 && stop !== 1'b0; n++)
			cyc(1);
		tmo(n, 10);
		chk("floor", 16'h1068, floor);
		chk("req", 1'b0, mreq);
		chk_reg(COA_OFS_MODE_CTRL, 8'h00);
	endtask : t_remeas

	// floor is 4200 mV here
	task automatic t_floor();
		chk("floor_thr", 4200 * 80 / 100, fthr);
		u_host.wr_reg(COA_OFS_ILIM_ALERT, 8'h4B);
		cyc(2);
		chk("floor_thr", 4200 * 90 / 100, fthr);
		u_host.wr_reg(COA_OFS_ALERT_THR, 8'h64);
		cyc(2);
		chk("floor_thr", 4200, fthr);
		vin = 16'h1004;
		cyc(3);
		chk("alert", 1'b1, alert);
		vin = 16'h4E20;
		cyc(3);
		chk("alert", 1'b0, alert);
	endtask : t_floor

	task automatic t_restore();
		int n;
		strap = 2'h2;
		u_host.wr_reg(COA_OFS_SRC_EN, 8'h5C);
		chk("src_en", 8'h5C, srcen);
		u_host.wr_reg(COA_OFS_MODE_CTRL, 8'hC0);
		for (n = 0; n < 6 && sys1 !== 1'b1; n++)
			cyc(1);
		tmo(n, 6);
		chk("load", 1'b1, cvld);
		chk("cells", 2'h2, cells);
		cyc(1);
		chk("pulse", 1'b0, sys1);
		chk("hiz", 1'b0, hiz);
		chk("floor", 16'h1068, floor);
		chk("src_en", 8'hA0, srcen);
		chk_reg(COA_OFS_MODE_CTRL, 8'h00);
		chk_reg(COA_OFS_ALERT_THR, 8'h65);
		chk_reg(COA_OFS_ILIM_ALERT, 8'h4A);
	endtask : t_restore

	// short burst first: the count must restart after it drops
	task automatic deg_one(input logic sel, input int tg);
		int n;
		cyc(2);
		set_ev(sel, 1'b1);
		cyc(tg - 2);
		chk("early", 1'b0, alert);
		set_ev(sel, 1'b0);
		cyc(1);
		set_ev(sel, 1'b1);
		for (n = 0; n < tg + 8 && alert !== 1'b1; n++)
			cyc(1);
		tmo(n, tg + 8);
		chk("deglitch", 1'b1, n >= tg - 1 && n <= tg + 2);
		set_ev(sel, 1'b0);
		cyc(3);
		chk("clear", 1'b0, alert);
	endtask : deg_one

	task automatic t_deg();
		int ct [4] = '{COA_CRIT_0_CYC, C1, C2, C3};
		for (int c = 0; c < 4; c++) begin
			u_host.wr_reg(COA_OFS_ILIM_ALERT, {5'h09, c[1:0], 1'b0});
			deg_one(1'b1, ct[c]);
		end
		u_host.wr_reg(COA_OFS_ALERT_THR, 8'h67);
		deg_one(1'b0, NL);
		u_host.wr_reg(COA_OFS_ALERT_THR, 8'h65);
		deg_one(1'b0, NS);
	endtask : t_deg

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cyc(2);
		t_reset();
		t_hiz();
		t_thr();
		t_ilim();
		t_remeas();
		t_floor();
		t_restore();
		t_deg();
		end_of_test();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		$display("[FAIL] run expected done seen timeout");
		end_of_test();
	end
endmodule : charger_option_alert_regs_tb
